// ---- wef_direction.sv ----
// decision logic of a directional wattmetric residual earth-fault function
module wef_direction
   import wef_pkg::*;
#(
   parameter int MS_CYCLES = MS_CYCLES_DEF
) (
   input  wire logic               MCLK,
   input  wire logic               RST,
   input  wire logic [3:0]         ADDR,
   input  wire logic [31:0]        WR_DATA,
   input  wire logic               WR_EN,
   input  wire logic               RD_EN,
   output logic      [31:0]        RD_DATA,
   input  wire logic               SMP_VALID,
   input  wire logic [15:0]        U_MAG,
   input  wire logic [15:0]        I_MAG,
   input  wire logic signed [8:0]  U_ANG,
   input  wire logic signed [8:0]  I_ANG,
   input  wire logic               BLOCK,
   output logic                    DIR_ENABLE,
   output logic                    POWER_OK,
   output logic                    DIR_VALID,
   output logic                    DECISION,
   output logic                    TRIP,
   output logic                    PWR_REPORT,
   output logic signed [31:0]      PWR_VALUE
);

   // bring any angle in -540..539 back to -180..179
   function automatic logic signed [10:0] wrap_deg(
      input logic signed [10:0] v);
      logic signed [10:0] r;
      r = v;
      if (r >= DEG_180) r = r - DEG_360;
      if (r < -DEG_180) r = r + DEG_360;
      if (r >= DEG_180) r = r - DEG_360;
      if (r < -DEG_180) r = r + DEG_360;
      return r;
   endfunction

   // cosine in Q2.14 by rational approximation; error under 0.2 %, which is
   // well inside the protection accuracy and avoids a large table
   function automatic logic signed [15:0] cos_q14(
      input logic signed [10:0] d);
      logic [10:0]  a;
      logic         neg;
      logic [31:0]  x2;
      logic [31:0]  num;
      logic [31:0]  den;
      logic [31:0]  q;
      a   = d[10] ? 11'(-d) : 11'(d);
      neg = 1'b0;
      if (a > 11'(DEG_90)) begin
         a   = 11'(DEG_180) - a;
         neg = 1'b1;
      end
      x2  = 32'(a) * 32'(a);
      num = (COS_K - (x2 << 2)) << COS_FRAC;
      den = COS_K + x2;
      q   = num / den;
      return neg ? -16'(signed'(q[15:0])) : 16'(signed'(q[15:0]));
   endfunction

   // settings
   logic [1:0]          mode_reg;
   logic [3:0]          umin_reg;
   logic [5:0]          imin_reg;
   logic [13:0]         plim_reg;
   logic [6:0]          half_ang_reg;
   logic signed [8:0]   ctr_ang_reg;
   logic [11:0]         rep_reg;
   logic [15:0]         opdly_reg;
   logic [15:0]         rstdly_reg;

   // measurement evaluation
   logic signed [10:0]  phase;
   logic signed [10:0]  centre;
   logic signed [10:0]  diff;
   logic [10:0]         diff_abs;
   logic signed [15:0]  cos_val;
   logic [31:0]         ui_prod;
   logic signed [48:0]  p_full;
   logic signed [34:0]  p_scaled;
   logic signed [34:0]  p_limit;
   logic                en_now;
   logic                pok_now;
   logic                dok_now;
   logic                active;
   logic signed [8:0]   phase_reg;

   // timers
   wef_tstate_t         tstate_reg;
   logic [16:0]         ms_cnt_reg;
   logic                ms_tick_reg;
   logic [9:0]          sec_ms_reg;
   logic                sec_tick_reg;
   logic [15:0]         tcnt_reg;
   logic [11:0]         rep_cnt_reg;

   // register writes; out-of-range values are stored as written
   always_ff @(posedge MCLK) begin
      if (RST) begin
         mode_reg   <= 2'(MODE_OFF);
         umin_reg   <= UMIN_RST;
         imin_reg   <= IMIN_RST;
         plim_reg   <= PLIM_RST;
         half_ang_reg <= HALFW_RST;
         ctr_ang_reg  <= CENTRE_RST;
         rep_reg    <= REP_RST;
         opdly_reg  <= OPDLY_RST;
         rstdly_reg <= RSTDLY_RST;
      end else if (WR_EN) begin
         case (ADDR)
            ADDR_MODE:   mode_reg   <= WR_DATA[1:0];
            ADDR_UMIN:   umin_reg   <= WR_DATA[3:0];
            ADDR_IMIN:   imin_reg   <= WR_DATA[5:0];
            ADDR_PLIM:   plim_reg   <= WR_DATA[13:0];
            ADDR_HALFW:  half_ang_reg <= WR_DATA[6:0];
            ADDR_CENTRE: ctr_ang_reg  <= WR_DATA[8:0];
            ADDR_REP:    rep_reg    <= WR_DATA[11:0];
            ADDR_OPDLY:  opdly_reg  <= WR_DATA[15:0];
            ADDR_RSTDLY: rstdly_reg <= WR_DATA[15:0];
            default: ;
         endcase
      end
   end

   // read port: data stands only in the cycle after the strobe
   always_ff @(posedge MCLK) begin
      if (RST) begin
         RD_DATA <= 32'h0;
      end else if (RD_EN) begin
         case (ADDR)
            ADDR_MODE:   RD_DATA <= {30'h0, mode_reg};
            ADDR_UMIN:   RD_DATA <= {28'h0, umin_reg};
            ADDR_IMIN:   RD_DATA <= {26'h0, imin_reg};
            ADDR_PLIM:   RD_DATA <= {18'h0, plim_reg};
            ADDR_HALFW:  RD_DATA <= {25'h0, half_ang_reg};
            ADDR_CENTRE: RD_DATA <= 32'(ctr_ang_reg);
            ADDR_REP:    RD_DATA <= {20'h0, rep_reg};
            ADDR_OPDLY:  RD_DATA <= {16'h0, opdly_reg};
            ADDR_RSTDLY: RD_DATA <= {16'h0, rstdly_reg};
            ADDR_STATUS: RD_DATA <= {27'h0, TRIP, DECISION, DIR_VALID,
                                     POWER_OK, DIR_ENABLE};
            ADDR_POWER:  RD_DATA <= PWR_VALUE;
            ADDR_ANGLE:  RD_DATA <= 32'(phase_reg);
            default:     RD_DATA <= 32'h0;
         endcase
      end else begin
         RD_DATA <= 32'h0;
      end
   end

   // angle, window and power arithmetic on the current sample
   always_comb begin
      phase = wrap_deg(11'(I_ANG) - 11'(U_ANG));
      centre = (mode_reg == 2'(MODE_BACKWARD))
             ? wrap_deg(11'(ctr_ang_reg) + DEG_180) : 11'(ctr_ang_reg);
      diff     = wrap_deg(phase - centre);
      diff_abs = diff[10] ? 11'(-diff) : 11'(diff);
      // inside centre plus or minus half-width
      dok_now  = diff_abs <= 11'(half_ang_reg);
      // power uses the same centre as the window
      cos_val  = cos_q14(diff);
      ui_prod  = 32'(U_MAG) * 32'(I_MAG);
      p_full   = signed'({17'h0, ui_prod}) * 49'(cos_val);
      p_scaled = 35'(p_full >>> COS_FRAC);
      p_limit  = 35'(32'(plim_reg) * 32'(PLIM_SCALE));
      pok_now  = p_scaled > p_limit;
      // both magnitudes strictly above their limits
      en_now   = (U_MAG > 16'(umin_reg) * PCT_SCALE)
              && (I_MAG > 16'(imin_reg) * PCT_SCALE);
   end

   // mode Off or the block input suppress the decision and the trip
   assign active = (mode_reg != 2'(MODE_OFF)) && !BLOCK;

   // flags and power follow each sample strobe
   always_ff @(posedge MCLK) begin
      if (RST) begin
         DIR_ENABLE <= 1'b0;
         POWER_OK   <= 1'b0;
         DIR_VALID  <= 1'b0;
         DECISION   <= 1'b0;
         PWR_VALUE  <= 32'sh0;
         phase_reg  <= 9'sh0;
      end else begin
         if (SMP_VALID) begin
            DIR_ENABLE <= en_now;
            POWER_OK   <= pok_now;
            DIR_VALID  <= dok_now;
            phase_reg  <= 9'(phase);
            // saturate; only exceeded with residuals far above rated
            if (p_scaled > 35'sh07fffffff)
               PWR_VALUE <= 32'sh7fffffff;
            else if (p_scaled < -35'sh080000000)
               PWR_VALUE <= -32'sh7fffffff - 32'sh1;
            else
               PWR_VALUE <= 32'(p_scaled);
         end
         // all four conditions at once, gated by mode and block
         if (!active)
            DECISION <= 1'b0;
         else if (SMP_VALID)
            DECISION <= en_now && dok_now && pok_now;
      end
   end

   // millisecond and second time base, free running
   always_ff @(posedge MCLK) begin
      if (RST) begin
         ms_cnt_reg   <= 17'h0;
         ms_tick_reg  <= 1'b0;
         sec_ms_reg   <= 10'h0;
         sec_tick_reg <= 1'b0;
      end else begin
         ms_tick_reg  <= 1'b0;
         sec_tick_reg <= 1'b0;
         if (ms_cnt_reg == 17'(MS_CYCLES - 1)) begin
            ms_cnt_reg  <= 17'h0;
            ms_tick_reg <= 1'b1;
         end else begin
            ms_cnt_reg <= ms_cnt_reg + 17'h1;
         end
         if (ms_tick_reg) begin
            if (sec_ms_reg == 10'(MS_PER_SEC - 1)) begin
               sec_ms_reg   <= 10'h0;
               sec_tick_reg <= 1'b1;
            end else begin
               sec_ms_reg <= sec_ms_reg + 10'h1;
            end
         end
      end
   end

   // definite-time operate and reset timer, counting whole milliseconds
   always_ff @(posedge MCLK) begin
      if (RST) begin
         tstate_reg <= T_IDLE;
         tcnt_reg   <= 16'h0;
         TRIP       <= 1'b0;
      end else if (!active) begin
         // immediate clear on block or Off
         tstate_reg <= T_IDLE;
         tcnt_reg   <= 16'h0;
         TRIP       <= 1'b0;
      end else begin
         case (tstate_reg)
            T_IDLE: begin
               tcnt_reg <= 16'h0;
               if (DECISION) begin
                  if (opdly_reg == 16'h0) begin
                     tstate_reg <= T_TRIPPED;
                     TRIP       <= 1'b1;
                  end else begin
                     tstate_reg <= T_PICKUP;
                  end
               end
            end
            T_PICKUP: begin
               if (!DECISION) begin
                  tstate_reg <= T_IDLE;
               end else if (ms_tick_reg) begin
                  if (tcnt_reg == opdly_reg - 16'h1) begin
                     tstate_reg <= T_TRIPPED;
                     TRIP       <= 1'b1;
                  end
                  tcnt_reg <= tcnt_reg + 16'h1;
               end
            end
            T_TRIPPED: begin
               tcnt_reg <= 16'h0;
               if (!DECISION) begin
                  if (rstdly_reg == 16'h0) begin
                     tstate_reg <= T_IDLE;
                     TRIP       <= 1'b0;
                  end else begin
                     tstate_reg <= T_RELEASE;
                  end
               end
            end
            T_RELEASE: begin
               // a returning decision keeps the trip and restarts the wait
               if (DECISION) begin
                  tstate_reg <= T_TRIPPED;
                  tcnt_reg   <= 16'h0;
               end else if (ms_tick_reg) begin
                  if (tcnt_reg == rstdly_reg - 16'h1) begin
                     tstate_reg <= T_IDLE;
                     TRIP       <= 1'b0;
                  end
                  tcnt_reg <= tcnt_reg + 16'h1;
               end
            end
            default: begin
               tstate_reg <= T_IDLE;
               tcnt_reg   <= 16'h0;
               TRIP       <= 1'b0;
            end
         endcase
      end
   end

   // periodic power report, one pulse per interval with PWR_VALUE beside it
   always_ff @(posedge MCLK) begin
      if (RST) begin
         rep_cnt_reg <= 12'h0;
         PWR_REPORT  <= 1'b0;
      end else begin
         PWR_REPORT <= 1'b0;
         if (rep_reg == 12'h0) begin
            rep_cnt_reg <= 12'h0;
         end else if (sec_tick_reg) begin
            if (rep_cnt_reg >= rep_reg - 12'h1) begin
               rep_cnt_reg <= 12'h0;
               PWR_REPORT  <= 1'b1;
            end else begin
               rep_cnt_reg <= rep_cnt_reg + 12'h1;
            end
         end
      end
   end

endmodule // wef_direction

// ---- wef_pkg.sv ----
// shared constants and types for the wattmetric earth-fault direction block
package wef_pkg;

   // clock and time base
   localparam int CLK_PERIOD_NS  = 10;
   localparam int TICK_PERIOD_MS = 1;
   localparam int MS_CYCLES_DEF  = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
   localparam int MS_PER_SEC     = 1000;

   // register word addresses
   localparam logic [3:0] ADDR_MODE   = 4'h0;
   localparam logic [3:0] ADDR_UMIN   = 4'h1;
   localparam logic [3:0] ADDR_IMIN   = 4'h2;
   localparam logic [3:0] ADDR_PLIM   = 4'h3;
   localparam logic [3:0] ADDR_HALFW  = 4'h4;
   localparam logic [3:0] ADDR_CENTRE = 4'h5;
   localparam logic [3:0] ADDR_REP    = 4'h6;
   localparam logic [3:0] ADDR_OPDLY  = 4'h7;
   localparam logic [3:0] ADDR_RSTDLY = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'h9;
   localparam logic [3:0] ADDR_POWER  = 4'ha;
   localparam logic [3:0] ADDR_ANGLE  = 4'hb;

   // status register bit positions
   localparam int ST_BIT_ENABLE   = 0;
   localparam int ST_BIT_POWER_OK = 1;
   localparam int ST_BIT_DIR_OK   = 2;
   localparam int ST_BIT_DECISION = 3;
   localparam int ST_BIT_TRIP     = 4;

   // reset values of the settings
   localparam logic [3:0]  UMIN_RST   = 4'h2;    // percent of rated voltage
   localparam logic [5:0]  IMIN_RST   = 6'h05;   // percent of rated current
   localparam logic [13:0] PLIM_RST   = 14'h00fa; // 2.50 % in 0.01 % units
   localparam logic [6:0]  HALFW_RST  = 7'h55;   // 85 degrees
   localparam logic [8:0]  CENTRE_RST = 9'h000;  // 0 degrees
   localparam logic [11:0] REP_RST    = 12'h00a; // 10 seconds
   localparam logic [15:0] OPDLY_RST  = 16'h0064; // 100 ms
   localparam logic [15:0] RSTDLY_RST = 16'h0064; // 100 ms

   // scaling: magnitudes are in 0.01 % of rated, so percent times this
   localparam logic [15:0] PCT_SCALE  = 16'h0064;
   // power limit (0.01 %) times this gives the product scale (0.01 %)^2
   localparam logic [15:0] PLIM_SCALE = 16'h2710;
   localparam int          COS_FRAC   = 14;       // cosine fraction bits

   // angle constants in degrees
   localparam logic signed [10:0] DEG_90   = 11'sh05a;
   localparam logic signed [10:0] DEG_180  = 11'sh0b4;
   localparam logic signed [10:0] DEG_360  = 11'sh168;
   localparam logic [31:0]        COS_K    = 32'h00007e90; // 32400, rational cosine

   typedef enum logic [1:0] {MODE_OFF, MODE_FORWARD, MODE_BACKWARD} wef_mode_t;
   typedef enum logic [1:0] {T_IDLE, T_PICKUP, T_TRIPPED, T_RELEASE} wef_tstate_t;

endpackage // wef_pkg

// ---- wef_direction_asserts.sv ----
// port-level checks for the wattmetric earth-fault direction block
module wef_chk (
   input wire logic               MCLK,
   input wire logic               RST,
   input wire logic               RD_EN,
   input wire logic [31:0]        RD_DATA,
   input wire logic               SMP_VALID,
   input wire logic               BLOCK,
   input wire logic               DIR_ENABLE,
   input wire logic               POWER_OK,
   input wire logic               DIR_VALID,
   input wire logic               DECISION,
   input wire logic               TRIP,
   input wire logic               PWR_REPORT,
   input wire logic signed [31:0] PWR_VALUE
);
   timeunit 1ns;
   timeprecision 1ps;
   // one clock domain, so clock and reset are stated once
   default clocking dcb @(posedge MCLK);
   endclocking
   default disable iff (RST);

   a_dec_all_four:
      assert property (DECISION |-> DIR_ENABLE && POWER_OK && DIR_VALID)
      else $error("decision high without all conditions");
   a_block_dec:
      assert property (BLOCK |=> !DECISION)
      else $error("decision survived the block input");
   a_block_trip:
      assert property (BLOCK |=> !TRIP)
      else $error("trip survived the block input");
   a_flags_hold:
      assert property (!SMP_VALID |=>
                       $stable({DIR_ENABLE, POWER_OK, DIR_VALID}))
      else $error("flags changed without a sample");
   a_power_hold:
      assert property (!SMP_VALID |=> $stable(PWR_VALUE))
      else $error("power value changed without a sample");
   a_dec_on_sample:
      assert property ($rose(DECISION) |-> $past(SMP_VALID))
      else $error("decision rose without a sample");
   a_trip_cause:
      assert property ($rose(TRIP) |-> $past(DECISION))
      else $error("trip rose without a decision");
   a_report_gap:
      assert property (PWR_REPORT |=> !PWR_REPORT [*8])
      else $error("report pulses too close together");
   a_read_idle:
      assert property (!$past(RD_EN) |-> RD_DATA == 32'h0)
      else $error("read data outside its cycle");

   // main scenarios that the bench should reach
   c_trip: cover property ($rose(TRIP));
   c_report: cover property (PWR_REPORT);
   c_block: cover property (BLOCK && TRIP);
endmodule // wef_chk

bind wef_direction wef_chk i_wef_chk (.MCLK(MCLK), .RST(RST), .RD_EN(RD_EN),
   .RD_DATA(RD_DATA), .SMP_VALID(SMP_VALID), .BLOCK(BLOCK),
   .DIR_ENABLE(DIR_ENABLE), .POWER_OK(POWER_OK), .DIR_VALID(DIR_VALID),
   .DECISION(DECISION), .TRIP(TRIP), .PWR_REPORT(PWR_REPORT),
   .PWR_VALUE(PWR_VALUE));

// ---- wef_front_end.sv ----
// behavioural measurement front end that presents residual phasor samples
module wef_front_end (
   input  wire logic              clk,
   input  wire logic              go,
   input  wire logic [15:0]       u,
   input  wire logic [15:0]       i,
   input  wire logic signed [8:0] ua,
   input  wire logic signed [8:0] ia,
   output logic                   smp,
   output logic [15:0]            um,
   output logic [15:0]            im,
   output logic signed [8:0]      uan,
   output logic signed [8:0]      ian
);
   timeunit 1ns;
   timeprecision 1ps;
   // defined levels from time zero
   initial begin
      smp = 1'b0;
      {um, im, uan, ian} = '0;
   end
   // magnitudes and angles with strobe
   // off the strobe the lines toggle, so stale data is never trusted
   always @(posedge clk) begin
      smp <= go;
      um  <= go ? u : ~um;
      im  <= go ? i : ~im;
      uan <= go ? ua : ~uan;
      ian <= go ? ia : ~ian;
   end
endmodule // wef_front_end

// ---- test_wattmetric_earth_fault_direction.sv ----
// self-checking bench for the wattmetric earth-fault direction block
module test_wattmetric_earth_fault_direction import wef_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic               mclk, rst, wr_en, rd_en, blk, go, smp;
   logic               den, pok, dval, dec, trip, rep;
   logic [3:0]         addr;
   logic [31:0]        wr_data, rd_data;
   logic [15:0]        u, i, um, im;
   logic signed [8:0]  ua, ia, uan, ian;
   logic signed [31:0] pwr;
   int                 errors, n_compared, cyc, n, k;
   int                 dflt [10] = '{0, 2, 5, 250, 85, 0, 10, 100, 100, 0};

   wef_direction #(.MS_CYCLES(10)) i_wef_direction (.MCLK(mclk), .RST(rst),
      .ADDR(addr), .WR_DATA(wr_data), .WR_EN(wr_en), .RD_EN(rd_en),
      .RD_DATA(rd_data), .SMP_VALID(smp), .U_MAG(um), .I_MAG(im),
      .U_ANG(uan), .I_ANG(ian), .BLOCK(blk), .DIR_ENABLE(den),
      .POWER_OK(pok), .DIR_VALID(dval), .DECISION(dec), .TRIP(trip),
      .PWR_REPORT(rep), .PWR_VALUE(pwr));
   wef_front_end i_wef_front_end (.clk(mclk), .go(go), .u(u), .i(i),
      .ua(ua), .ia(ia), .smp(smp), .um(um), .im(im), .uan(uan), .ian(ian));

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   // hang guard: the report tests alone need some 41000 cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 70000) begin
         errors++;
         results();
      end
   end

   task results();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      n_compared++;
      if (s !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge mclk);
      wr_en <= 1'b0;
   endtask
   task rc(input logic [3:0] a, input logic [31:0] e);
      @(posedge mclk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge mclk);
      rd_en <= 1'b0;
      #1;
      chk("register", e, rd_data);
   endtask
   // one sample, then flags {enable, power, window, decision}
   task sc(input logic [15:0] uu, ii, input logic signed [8:0] a, b,
           input logic [3:0] e);
      @(posedge mclk);
      {u, i, ua, ia} <= {uu, ii, a, b};
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      @(posedge mclk);
      #1;
      chk("flags", 32'(e), 32'({den, pok, dval, dec}));
   endtask
   task wait_trip(input logic v, input int lim);
      for (n = 0; trip !== v && n < lim; n++) @(posedge mclk) #1;
      chk("trip", 32'(v), 32'(trip));
   endtask
   task wait_rep(input int lim);
      for (n = 0; rep !== 1'b1 && n < lim; n++) @(posedge mclk) #1;
   endtask

   // main sequence
   initial begin
      {rst, wr_en, rd_en, blk, go, addr, wr_data} = {5'h10, 36'h0};
      {u, i, ua, ia} = '0;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      for (k = 0; k < 10; k++) rc(4'(k), 32'(dflt[k]));
      rc(4'hc, 32'h0);
      wr(ADDR_CENTRE, 32'h1a6); // isolated network centre
      rc(ADDR_CENTRE, 32'hffffffa6);
      $display("test registers done");
      wr(ADDR_CENTRE, 32'h0);
      wr(ADDR_OPDLY, 32'h3);
      wr(ADDR_RSTDLY, 32'h2);
      sc(16'd2000, 16'd2000, 0, 0, 4'b1110);
      wr(ADDR_MODE, 32'h1);
      sc(16'd2000, 16'd2000, 0, 0, 4'b1111);
      chk("power", 1, 32'(pwr > 3980000 && pwr < 4020000));
      repeat (18) @(posedge mclk);
      #1;
      chk("trip early", 0, 32'(trip));
      wait_trip(1'b1, 30);
      rc(ADDR_STATUS, 32'h1f);
      sc(16'd100, 16'd2000, 0, 0, 4'b0010);
      repeat (5) @(posedge mclk);
      #1;
      chk("trip held", 1, 32'(trip));
      wait_trip(1'b0, 30);
      sc(16'd2000, 16'd2000, 0, 0, 4'b1111);
      wait_trip(1'b1, 40);
      @(posedge mclk);
      blk <= 1'b1;
      @(posedge mclk);
      #1;
      chk("blocked", 0, 32'({dec, trip}));
      sc(16'd2000, 16'd2000, 0, 0, 4'b1110);
      @(posedge mclk);
      blk <= 1'b0;
      $display("test timer done");
      sc(16'd200, 16'd2000, 0, 0, 4'b0010);
      sc(16'd2000, 16'd500, 0, 0, 4'b0010);
      sc(16'd2000, 16'd1500, 0, 0, 4'b1111);
      sc(16'd1500, 16'd1500, 0, 0, 4'b1010);
      sc(16'd2000, 16'd2000, -100, -15, 4'b1010);
      rc(ADDR_ANGLE, 32'd85);
      sc(16'd2000, 16'd2000, 0, 86, 4'b1000);
      sc(16'd2000, 16'd2000, 170, -105, 4'b1010);
      wr(ADDR_HALFW, 32'd30);
      sc(16'd2000, 16'd2000, 0, 31, 4'b1100);
      sc(16'd2000, 16'd2000, 0, -30, 4'b1111);
      wr(ADDR_CENTRE, 32'h1a6);
      sc(16'd2000, 16'd2000, 0, -90, 4'b1111);
      wr(ADDR_CENTRE, 32'h0);
      wr(ADDR_HALFW, 32'd85);
      wr(ADDR_MODE, 32'h2);
      sc(16'd2000, 16'd2000, 0, 0, 4'b1000);
      chk("reverse power", 1, 32'(pwr < 0));
      sc(16'd2000, 16'd2000, 0, -180, 4'b1111);
      wait_trip(1'b1, 40);
      wr(ADDR_MODE, 32'h0);
      @(posedge mclk);
      #1;
      chk("mode off", 0, 32'({dec, trip}));
      $display("test window done");
      wr(ADDR_REP, 32'h1);
      wait_rep(20100);
      chk("report", 1, 32'(rep));
      @(posedge mclk);
      #1;
      wait_rep(20100);
      chk("report gap", 10000, n + 1);
      wr(ADDR_REP, 32'h0);
      wait_rep(21000);
      chk("no report", 0, 32'(rep));
      $display("test report done");
      results();
   end
endmodule // test_wattmetric_earth_fault_direction
